/* core/rtc_alarm_calib_watchdog.v */
// Alarm comparator, calibrated seconds divider, frequency test output,
// watchdog timer and supply-fail reset of a battery-backed clock device.
// Assumes synchronous bus strobes, an oscillator tick input and a time
// counter outside that supplies BCD time and accepts the calibrated tick.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_support_consts.vh"

module rtc_alarm_calib_watchdog #(
    parameter integer TREC_CYCLES = (`TREC_US * (`SYS_HZ / 1000000)),
    parameter integer OSC_DIV = 6104
) (
    input wire clk_sys_i,
    input wire nrst_i,
    input wire osc_tick_i,
    input wire [14:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    input wire [7:0] time_sec_i,
    input wire [7:0] time_min_i,
    input wire [7:0] time_hour_i,
    input wire [7:0] time_date_i,
    input wire on_battery_i,
    input wire supply_ok_i,
    input wire watchdog_kick_in_i,
    output wire sec_tick_o,
    output wire irq_test_out_n_o,
    output wire irq_test_out_n_oe_o,
    output wire rst_n_o,
    output wire rst_n_oe_o
);

    ////////////////////////////////////////////////////////////////////////
    reg rst_s1_ff;
    reg rst_s2_ff;
    wire rst_n;
    always @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end
        else
        begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end
    assign rst_n = rst_s2_ff;

    function match_addr;
        input [14:0] a;
        input [14:0] r;
        begin
            match_addr = (a == r);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    reg [7:0] alm_sec_ff, alm_min_ff, alm_hour_ff, alm_date_ff;
    reg alarm_irq_enable_ff, alarm_backup_enable_ff;
    reg [7:0] wd_ctrl_ff;
    reg [7:0] clk_ctrl_ff;
    reg freq_test_enable_ff;
    reg osc_halt_ff;
    reg alarm_flag_ff, alarm_irq_ff, wd_timeout_flag_ff, wd_irq_ff;
    reg pwr_ok_ff;
    reg [31:0] rst_cnt_ff;
    reg kick_ff;
    reg [31:0] wd_cnt_ff;
    reg [7:0] div_ff;
    reg [6:0] tick_ff;
    reg [5:0] cal_min_ff;
    reg [5:0] sec_in_min_ff;
    reg cal_done_ff;
    reg [8:0] extra_ff;
    reg sec_pulse_ff;
    reg sq_ff;

    wire [4:0] wd_multiplier = wd_ctrl_ff[6:2];
    wire [1:0] wd_resolution = wd_ctrl_ff[1:0];
    wire wd_steer = wd_ctrl_ff[`BIT_WD_STEER];
    wire [3:0] alarm_repeat_mask = {alm_date_ff[`BIT_RPT], alm_hour_ff[`BIT_RPT],
                                    alm_min_ff[`BIT_RPT], alm_sec_ff[`BIT_RPT]};
    wire flags_rd = rd_i && match_addr(addr_i, `ADDR_FLAGS);
    wire wd_wr = wr_i && match_addr(addr_i, `ADDR_WD_CTRL);
    wire pwr_down = pwr_ok_ff && !supply_ok_i;

    ////////////////////////////////////////////////////////////////////////
    // Alarm match on each second update
    reg alarm_hit;
    always @*
    begin
        alarm_hit = 1'b0;
        case (alarm_repeat_mask)
            `RPT_MIN: alarm_hit = (time_sec_i[6:0] == alm_sec_ff[6:0]);
            `RPT_HOUR: alarm_hit = (time_sec_i[6:0] == alm_sec_ff[6:0]) &&
                                   (time_min_i[6:0] == alm_min_ff[6:0]);
            `RPT_DAY: alarm_hit = (time_sec_i[6:0] == alm_sec_ff[6:0]) &&
                                  (time_min_i[6:0] == alm_min_ff[6:0]) &&
                                  (time_hour_i[5:0] == alm_hour_ff[5:0]);
            `RPT_MONTH: alarm_hit = (time_sec_i[6:0] == alm_sec_ff[6:0]) &&
                                    (time_min_i[6:0] == alm_min_ff[6:0]) &&
                                    (time_hour_i[5:0] == alm_hour_ff[5:0]) &&
                                    (time_date_i[5:0] == alm_date_ff[5:0]);
            default: alarm_hit = 1'b1;
        endcase
    end
    wire alarm_event = sec_pulse_ff && alarm_hit;

    ////////////////////////////////////////////////////////////////////////
    // Watchdog timeout in 1/16 s units, from the calibrated tick
    reg [10:0] wd_units;
    always @*
    begin
        case (wd_resolution)
            2'b00: wd_units = {6'h00, wd_multiplier};
            2'b01: wd_units = {4'h0, wd_multiplier, 2'b00};
            2'b10: wd_units = {2'b00, wd_multiplier, 4'h0};
            default: wd_units = {wd_multiplier, 6'h00};
        endcase
    end
    wire wd_enabled = (wd_ctrl_ff != `ZERO8);
    reg [1:0] kick_sync_ff;
    wire kick_edge = kick_ff ^ kick_sync_ff[1];
    // Every eighth stage wrap is one unit; a halted divider gives none
    wire unit_tick = osc_tick_i && !osc_halt_ff && (div_ff == 8'hff) &&
                     (tick_ff[2:0] == 3'h7);
    wire wd_expire = wd_enabled && !wd_irq_ff && unit_tick &&
                     (wd_cnt_ff + 32'd1 >= {21'h0, wd_units});

    ////////////////////////////////////////////////////////////////////////
    // Divider, calibration and seconds tick
    wire [4:0] cal_mag = clk_ctrl_ff[4:0];
    wire cal_pos = clk_ctrl_ff[`BIT_CAL_SIGN];
    wire cal_active = (cal_min_ff < {cal_mag, 1'b0}) &&
                      (cal_min_ff < 6'd`CAL_MIN_ELIG) && !cal_done_ff;
    wire stage_wrap = osc_tick_i && (div_ff == 8'hff);
    always @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_ff <= 8'h00;
            tick_ff <= 7'h00;
            cal_min_ff <= 6'h00;
            sec_in_min_ff <= 6'h00;
            cal_done_ff <= 1'b0;
            extra_ff <= 9'h000;
            sec_pulse_ff <= 1'b0;
            sq_ff <= 1'b0;
        end
        else
        begin
            sec_pulse_ff <= 1'b0;
            if (osc_tick_i && !osc_halt_ff)
            begin
                div_ff <= div_ff + 8'h01;
                if (div_ff[4:0] == 5'h1f)
                    sq_ff <= ~sq_ff;
                if (stage_wrap)
                begin
                    if (extra_ff != 9'h000)
                        extra_ff <= extra_ff - 9'h100;
                    else if (tick_ff == 7'h7f)
                    begin
                        tick_ff <= 7'h00;
                        sec_pulse_ff <= 1'b1;
                        if (cal_active && !cal_pos)
                        begin
                            extra_ff <= 9'h100;
                            cal_done_ff <= 1'b1;
                        end
                        if (sec_in_min_ff == 6'd59)
                        begin
                            sec_in_min_ff <= 6'h00;
                            cal_done_ff <= 1'b0;
                            cal_min_ff <= cal_min_ff + 6'h01;
                        end
                        else
                            sec_in_min_ff <= sec_in_min_ff + 6'h01;
                    end
                    else
                    begin
                        tick_ff <= tick_ff + 7'h01;
                        // Split one stage: next wrap 128 cycles early, low bits keep phase
                        if (cal_active && cal_pos && tick_ff == 7'h7e)
                        begin
                            div_ff <= div_ff + 8'h81;
                            cal_done_ff <= 1'b1;
                        end
                    end
                end
            end
        end
    end
    assign sec_tick_o = sec_pulse_ff;

    ////////////////////////////////////////////////////////////////////////
    // Registers, flags and watchdog
    always @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            alm_sec_ff <= 8'h00;
            alm_min_ff <= 8'h00;
            alm_hour_ff <= 8'h00;
            alm_date_ff <= 8'h00;
            alarm_irq_enable_ff <= 1'b0;
            alarm_backup_enable_ff <= 1'b0;
            wd_ctrl_ff <= 8'h00;
            clk_ctrl_ff <= 8'h00;
            freq_test_enable_ff <= 1'b0;
            osc_halt_ff <= 1'b0;
            alarm_flag_ff <= 1'b0;
            alarm_irq_ff <= 1'b0;
            wd_timeout_flag_ff <= 1'b0;
            wd_irq_ff <= 1'b0;
            wd_cnt_ff <= 32'h0;
            kick_ff <= 1'b0;
            kick_sync_ff <= 2'b00;
            pwr_ok_ff <= 1'b0;
            rst_cnt_ff <= 32'h0;
        end
        else
        begin
            kick_sync_ff <= {kick_sync_ff[0], watchdog_kick_in_i};
            kick_ff <= kick_sync_ff[1];
            pwr_ok_ff <= supply_ok_i;
            if (wr_i)
            begin
                if (match_addr(addr_i, `ADDR_ALM_SEC)) alm_sec_ff <= wdata_i;
                if (match_addr(addr_i, `ADDR_ALM_MIN)) alm_min_ff <= wdata_i;
                if (match_addr(addr_i, `ADDR_ALM_HOUR)) alm_hour_ff <= wdata_i;
                if (match_addr(addr_i, `ADDR_ALM_DATE)) alm_date_ff <= wdata_i;
                if (match_addr(addr_i, `ADDR_CLK_CTRL)) clk_ctrl_ff <= wdata_i;
                if (match_addr(addr_i, `ADDR_SECONDS)) osc_halt_ff <= wdata_i[`BIT_HALT];
                if (match_addr(addr_i, `ADDR_DAY)) freq_test_enable_ff <= wdata_i[`BIT_FT];
                if (match_addr(addr_i, `ADDR_IRQ_EN))
                begin
                    alarm_irq_enable_ff <= wdata_i[`BIT_IRQ_EN];
                    alarm_backup_enable_ff <= wdata_i[`BIT_BACKUP_EN];
                end
            end
            // Alarm flag: a set in the clearing cycle wins
            if (alarm_event)
            begin
                alarm_flag_ff <= 1'b1;
                alarm_irq_ff <= alarm_irq_enable_ff &&
                                (!on_battery_i || alarm_backup_enable_ff);
            end
            else if (flags_rd)
            begin
                alarm_flag_ff <= 1'b0;
                alarm_irq_ff <= 1'b0;
            end
            if (wd_expire)
                wd_timeout_flag_ff <= 1'b1;
            else if (flags_rd)
                wd_timeout_flag_ff <= 1'b0;
            if (wd_wr)
            begin
                wd_ctrl_ff <= wdata_i;
                wd_cnt_ff <= 32'h0;
                if (wdata_i == `ZERO8)
                    wd_irq_ff <= 1'b0;
            end
            else if (kick_edge)
                wd_cnt_ff <= 32'h0;
            else if (wd_expire)
            begin
                wd_cnt_ff <= 32'h0;
                if (wd_steer)
                begin
                    rst_cnt_ff <= TREC_CYCLES;
                    wd_ctrl_ff <= 8'h00;
                    freq_test_enable_ff <= 1'b0;
                    alarm_irq_enable_ff <= 1'b0;
                    alarm_backup_enable_ff <= 1'b0;
                end
                else
                    wd_irq_ff <= 1'b1;
            end
            else if (wd_enabled && unit_tick)
                wd_cnt_ff <= wd_cnt_ff + 32'd1;
            if (!supply_ok_i)
                rst_cnt_ff <= TREC_CYCLES;
            else if (rst_cnt_ff != 32'h0 && !(wd_expire && wd_steer))
                rst_cnt_ff <= rst_cnt_ff - 32'h1;
            if (pwr_down)
            begin
                wd_ctrl_ff <= 8'h00;
                freq_test_enable_ff <= 1'b0;
                wd_irq_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data and pins
    always @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            rdata_o <= 8'h00;
        else if (rd_i)
        begin
            rdata_o <= 8'h00;
            if (match_addr(addr_i, `ADDR_FLAGS))
            begin
                rdata_o[`BIT_WD_FLAG] <= wd_timeout_flag_ff;
                rdata_o[`BIT_ALM_FLAG] <= alarm_flag_ff;
            end
            if (match_addr(addr_i, `ADDR_WD_CTRL)) rdata_o <= wd_ctrl_ff;
            if (match_addr(addr_i, `ADDR_CLK_CTRL)) rdata_o <= clk_ctrl_ff;
            if (match_addr(addr_i, `ADDR_ALM_SEC)) rdata_o <= alm_sec_ff;
            if (match_addr(addr_i, `ADDR_ALM_MIN)) rdata_o <= alm_min_ff;
            if (match_addr(addr_i, `ADDR_ALM_HOUR)) rdata_o <= alm_hour_ff;
            if (match_addr(addr_i, `ADDR_ALM_DATE)) rdata_o <= alm_date_ff;
            if (match_addr(addr_i, `ADDR_IRQ_EN))
                rdata_o <= {alarm_irq_enable_ff, 1'b0, alarm_backup_enable_ff, 5'h00};
        end
    end

    wire irq_active = alarm_irq_ff || wd_irq_ff;
    wire test_on = !osc_halt_ff && freq_test_enable_ff && !alarm_irq_enable_ff &&
                   (wd_steer || !wd_enabled);
    wire pin_low = irq_active || (test_on && sq_ff);
    assign irq_test_out_n_o = 1'b0;
    assign irq_test_out_n_oe_o = pin_low;
    assign rst_n_o = 1'b0;
    assign rst_n_oe_o = (rst_cnt_ff != 32'h0) || !supply_ok_i;

endmodule
`default_nettype wire

/* core/rtc_support_consts.vh */
// Constants for the alarm, calibration, watchdog and reset support block.
// Assumes a byte-wide register bus decoded on 15-bit addresses.
`ifndef RTC_SUPPORT_CONSTS_VH
`define RTC_SUPPORT_CONSTS_VH
`define ADDR_FLAGS 15'h7ff0
`define ADDR_ALM_SEC 15'h7ff2
`define ADDR_ALM_MIN 15'h7ff3
`define ADDR_ALM_HOUR 15'h7ff4
`define ADDR_ALM_DATE 15'h7ff5
`define ADDR_IRQ_EN 15'h7ff6
`define ADDR_WD_CTRL 15'h7ff7
`define ADDR_CLK_CTRL 15'h7ff8
`define ADDR_SECONDS 15'h7ff9
`define ADDR_DAY 15'h7ffc
`define BIT_WD_FLAG 7
`define BIT_ALM_FLAG 6
`define BIT_IRQ_EN 7
`define BIT_BACKUP_EN 5
`define BIT_WD_STEER 7
`define BIT_FT 6
`define BIT_HALT 7
`define BIT_CAL_SIGN 5
`define BIT_RPT 7
`define RPT_SEC 4'hf
`define RPT_MIN 4'he
`define RPT_HOUR 4'hc
`define RPT_DAY 4'h8
`define RPT_MONTH 4'h0
`define OSC_HZ 32768
`define SYS_HZ 200000000
`define CAL_STAGE 256
`define CAL_SHORT 128
`define CAL_LONG 256
`define CAL_MIN_ELIG 62
`define CAL_CYCLE_MIN 64
`define TICKS_PER_SEC 128
`define TREC_US 200
`define ZERO8 8'h00
`endif

/* verification/host_cpu_model.sv */
// Host processor model: byte register bus and watchdog kick pin.
// Assumes strobes sampled on the rising edge, read data a cycle later.
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
    input wire logic clk_sys_i,
    input wire logic [7:0] rdata_i,
    output logic [14:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o,
    output logic kick_o
);
    initial
    begin
        addr_o = 15'h0000;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
        kick_o = 1'b0;
    end
    // Released lines show the inverse so stale values are never trusted
    task bus_wr(input logic [14:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clk_sys_i);
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask
    task bus_rd(input logic [14:0] a, output logic [7:0] d);
        @(negedge clk_sys_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clk_sys_i);
        rd_o = 1'b0;
        addr_o = ~a;
        @(negedge clk_sys_i);
        d = rdata_i;
    endtask
    task kick();
        @(negedge clk_sys_i);
        kick_o = ~kick_o;
    endtask
endmodule
`default_nettype wire

/* verification/rtc_support_chk.sv */
// Port-level checker for the alarm, watchdog and reset support block.
// Bound onto the block; everything runs on one clock.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_support_consts.vh"
module rtc_support_chk #(
    parameter integer TREC_CYCLES = 20
) (
    input wire clk_sys_i,
    input wire nrst_i,
    input wire [14:0] addr_i,
    input wire rd_i,
    input wire [7:0] rdata_o,
    input wire supply_ok_i,
    input wire sec_tick_o,
    input wire irq_test_out_n_o,
    input wire rst_n_o,
    input wire rst_n_oe_o
);
    // Length of the present reset pulse while supply is good
    reg [15:0] hi_cnt_ff;
    always @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            hi_cnt_ff <= 16'h0000;
        else if (rst_n_oe_o && supply_ok_i)
            hi_cnt_ff <= hi_cnt_ff + 16'h0001;
        else
            hi_cnt_ff <= 16'h0000;
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);
    sequence s_flag_rd;
        rd_i && addr_i == `ADDR_FLAGS && !sec_tick_o;
    endsequence
    sequence s_two_rd;
        s_flag_rd ##0 !$past(sec_tick_o) ##1 (!sec_tick_o) [*2] ##1 s_flag_rd;
    endsequence
    a_od_values: assert property (irq_test_out_n_o == 1'b0 && rst_n_o == 1'b0)
        else $error("open-drain pin value not low");
    a_rst_on_fail: assert property (!supply_ok_i |-> ##[0:3] rst_n_oe_o)
        else $error("reset pin not pulled on supply fail");
    a_rst_recover: assert property ($rose(supply_ok_i) |=> rst_n_oe_o [*8])
        else $error("reset released too early after supply return");
    a_rst_pulse_len: assert property ($fell(rst_n_oe_o) |->
        hi_cnt_ff >= TREC_CYCLES && hi_cnt_ff <= TREC_CYCLES + 3)
        else $error("reset pulse length wrong");
    a_tick_gap: assert property (sec_tick_o |=> !sec_tick_o [*8])
        else $error("seconds tick too close");
    a_flag_reread: assert property (s_two_rd |=> rdata_o[`BIT_ALM_FLAG] == 1'b0)
        else $error("alarm flag not cleared by read");
    a_rdata_holds: assert property (!rd_i |=> $stable(rdata_o))
        else $error("read data moved without a read");
    a_rst_hold_low: assert property (!supply_ok_i |=> ##3 rst_n_oe_o)
        else $error("reset pin dropped during supply fail");
endmodule
bind rtc_alarm_calib_watchdog rtc_support_chk #(.TREC_CYCLES(TREC_CYCLES)) i_chk (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .addr_i(addr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .supply_ok_i(supply_ok_i), .sec_tick_o(sec_tick_o),
    .irq_test_out_n_o(irq_test_out_n_o), .rst_n_o(rst_n_o), .rst_n_oe_o(rst_n_oe_o)
);
`default_nettype wire

/* verification/tb_rtc_alarm_calib_watchdog.sv */
// Self-checking bench for the alarm, calibration, watchdog and reset block.
// Assumes one oscillator tick per clock and the host model on the bus.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_support_consts.vh"
module tb_rtc_alarm_calib_watchdog;
    localparam integer TREC = 20;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic osc_tick = 1'b0;
    logic supply_ok = 1'b1;
    logic on_batt = 1'b0;
    logic [7:0] irq_en [2] = '{8'ha0, 8'h80};
    logic [7:0] now_bcd = 8'h00;
    logic [14:0] addr;
    logic [7:0] wdata, rdata, rv;
    logic wr, rd, kick, sec_tick, irq, irq_oe, rst, rst_oe;
    logic [14:0] ro_addr [5] = '{`ADDR_WD_CTRL, `ADDR_IRQ_EN, `ADDR_CLK_CTRL, `ADDR_FLAGS, 15'h0100};
    logic [7:0] cal [3] = '{8'h3f, 8'h1f, 8'h00};
    logic [7:0] alm [2][4] = '{'{8'h15, 8'hb3, 8'h87, 8'h89}, '{8'hc4, 8'h22, 8'h87, 8'h09}};
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int n;
    rtc_alarm_calib_watchdog #(.TREC_CYCLES(TREC)) i_dut (
        .clk_sys_i(clk), .nrst_i(nrst), .osc_tick_i(osc_tick), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .time_sec_i(now_bcd),
        .time_min_i(now_bcd), .time_hour_i(now_bcd), .time_date_i(now_bcd),
        .on_battery_i(on_batt), .supply_ok_i(supply_ok), .watchdog_kick_in_i(kick),
        .sec_tick_o(sec_tick), .irq_test_out_n_o(irq), .irq_test_out_n_oe_o(irq_oe),
        .rst_n_o(rst), .rst_n_oe_o(rst_oe)
    );
    host_cpu_model i_host (
        .clk_sys_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
        .rd_o(rd), .kick_o(kick)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_rng(input string what, input int lo, input int hi, input int got);
        n_checks++;
        if (got < lo || got > hi)
        begin
            num_errors++;
            $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    task automatic wait_pin(input bit on_rst, input int lim, output int c);
        c = 0;
        while ((on_rst ? rst_oe : irq_oe) !== 1'b1 && c < lim)
        begin
            @(negedge clk);
            c++;
        end
    endtask
    task automatic wait_low(output int c);
        c = 0;
        while (rst_oe === 1'b1 && c < 100)
        begin
            @(negedge clk);
            c++;
        end
    endtask
    // Waits for the seconds tick, then one cycle for the alarm to land
    task automatic wait_tick(output int c);
        c = 0;
        while (sec_tick !== 1'b1 && c < 40000)
        begin
            @(negedge clk);
            c++;
        end
        @(negedge clk);
    endtask
    // Pin changes over 320 cycles: ten for a 512 Hz wave at one tick a cycle
    task automatic count_chg(output int c);
        logic last;
        repeat (2) @(negedge clk);
        c = 0;
        last = irq_oe;
        repeat (320)
        begin
            @(negedge clk);
            c += (irq_oe !== last) ? 1 : 0;
            last = irq_oe;
        end
    endtask
    task automatic end_of_test();
        $display("Checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 98000)
        begin
            num_errors++;
            end_of_test();
        end
    end
    initial
    begin
        repeat (16) @(negedge clk);
        nrst = 1'b1;
        osc_tick = 1'b1;
        now_bcd = 8'h15;
        repeat (3) @(negedge clk);
        for (int k = 0; k < 5; k++)
        begin
            i_host.bus_rd(ro_addr[k], rv);
            check_val("reset byte", 8'h00, rv);
        end
        i_host.bus_wr(`ADDR_DAY, 8'h40);
        for (int k = 0; k < 3; k++)
        begin
            i_host.bus_wr(`ADDR_CLK_CTRL, cal[k]);
            i_host.bus_rd(`ADDR_CLK_CTRL, rv);
            check_val("calibration", cal[k], rv);
            count_chg(n);
            check_rng("test toggles", 10, 10, n);
        end
        i_host.bus_wr(`ADDR_WD_CTRL, 8'h08);
        count_chg(n);
        check_rng("test denied", 0, 0, n);
        i_host.bus_wr(`ADDR_DAY, 8'h00);
        i_host.bus_wr(`ADDR_WD_CTRL, 8'h08);
        wait_pin(0, 7000, n);
        check_rng("wd to irq", 2048, 6200, n);
        i_host.bus_rd(`ADDR_FLAGS, rv);
        check_val("wd flag", 8'h80, rv & 8'h80);
        check_val("irq held", 8'h01, {7'h00, irq_oe});
        i_host.bus_wr(`ADDR_WD_CTRL, 8'h00);
        repeat (2) @(negedge clk);
        check_val("irq freed", 8'h00, {7'h00, irq_oe});
        i_host.bus_rd(`ADDR_FLAGS, rv);
        check_val("wd flag", 8'h00, rv & 8'h80);
        i_host.bus_wr(`ADDR_WD_CTRL, 8'h08);
        repeat (4)
        begin
            wait_pin(0, 1500, n);
            check_rng("kicked wd", 1500, 1500, n);
            i_host.kick();
        end
        i_host.bus_wr(`ADDR_WD_CTRL, 8'h00);
        i_host.bus_wr(`ADDR_DAY, 8'h40);
        i_host.bus_wr(`ADDR_IRQ_EN, 8'ha0);
        i_host.bus_wr(`ADDR_WD_CTRL, 8'h84);
        wait_pin(1, 5000, n);
        check_rng("wd to reset", 1, 4100, n);
        wait_low(n);
        check_rng("reset pulse", TREC, TREC, n);
        for (int k = 0; k < 2; k++)
        begin
            i_host.bus_rd(ro_addr[k], rv);
            check_val("cleared by wd", 8'h00, rv);
        end
        count_chg(n);
        check_rng("test bit cleared", 0, 0, n);
        on_batt = 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            i_host.bus_wr(`ADDR_IRQ_EN, 8'h00);
            for (int j = 0; j < 4; j++)
                i_host.bus_wr(15'(`ADDR_ALM_SEC + j), alm[k][j]);
            i_host.bus_rd(`ADDR_FLAGS, rv);
            i_host.bus_wr(`ADDR_IRQ_EN, irq_en[k]);
            wait_tick(n);
            check_rng("alarm wait", 0, 32768, n);
            check_val("battery irq", {7'h00, k == 0}, {7'h00, irq_oe});
            i_host.bus_rd(`ADDR_FLAGS, rv);
            check_val("alarm flag", 8'h40, rv & 8'h40);
            check_val("irq cleared", 8'h00, {7'h00, irq_oe});
            i_host.bus_rd(`ADDR_FLAGS, rv);
            check_val("alarm flag", 8'h00, rv & 8'h40);
        end
        for (int j = 0; j < 4; j++)
            i_host.bus_wr(15'(`ADDR_ALM_SEC + j), 8'h00);
        on_batt = 1'b0;
        i_host.bus_wr(`ADDR_IRQ_EN, 8'h00);
        i_host.bus_wr(`ADDR_DAY, 8'h40);
        i_host.bus_wr(`ADDR_WD_CTRL, 8'h08);
        supply_ok = 1'b0;
        repeat (4) @(negedge clk);
        check_val("reset on fail", 8'h01, {7'h00, rst_oe});
        supply_ok = 1'b1;
        wait_low(n);
        check_rng("recovery", TREC, TREC + 4, n);
        i_host.bus_rd(`ADDR_WD_CTRL, rv);
        check_val("wd after fail", 8'h00, rv);
        count_chg(n);
        check_rng("test after fail", 0, 0, n);
        end_of_test();
    end
endmodule
`default_nettype wire
